// >>> prioritized_interrupt_controller.sv
// Purpose: Interrupt controller with three levels and a global gate counter.
// Assumes: Word-addressed 16-bit register port sampled on the same clock.
// Notes:   Source request inputs come from on-chip logic on this clock.
`timescale 1ns/1ps
module prioritized_interrupt_controller
	import intc_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic                   arst_n,
	input  wire logic [NUM_SOURCES-1:0] src_req,
	input  wire logic [15:0]            reg_addr,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [15:0]            reg_wdata,
	output logic      [15:0]            reg_rdata,
	output logic                        irq_req,
	output logic      [VEC_W-1:0]       irq_vector
);

	// ========================================================================
	// Reset release
	logic       rst_s1_q;
	logic       rst_n_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// ========================================================================
	// Decoding
	function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
		hit = (a == target);
	endfunction

	logic                    wr_en_lp_lo;
	logic                    wr_en_lp_hi;
	logic                    wr_en_hp_lo;
	logic                    wr_en_hp_hi;
	logic                    wr_flags_lo;
	logic                    wr_flags_hi;
	logic                    wr_cnt;
	logic                    wr_dis;
	logic                    wr_ena;

	assign wr_en_lp_lo = reg_wr && hit(reg_addr, ADDR_EN_LP_LO);
	assign wr_en_lp_hi = reg_wr && hit(reg_addr, ADDR_EN_LP_HI);
	assign wr_en_hp_lo = reg_wr && hit(reg_addr, ADDR_EN_HP_LO);
	assign wr_en_hp_hi = reg_wr && hit(reg_addr, ADDR_EN_HP_HI);
	assign wr_flags_lo = reg_wr && hit(reg_addr, ADDR_FLAGS_LO);
	assign wr_flags_hi = reg_wr && hit(reg_addr, ADDR_FLAGS_HI);
	assign wr_cnt      = reg_wr && hit(reg_addr, ADDR_GATE_CNT);
	assign wr_dis      = reg_wr && hit(reg_addr, ADDR_GLOB_DIS);
	assign wr_ena      = reg_wr && hit(reg_addr, ADDR_GLOB_ENA);

	// ========================================================================
	// Enable registers
	logic [NUM_SOURCES-1:0]  en_lp_q;
	logic [NUM_SOURCES-1:0]  en_hp_q;

	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			en_lp_q <= EN_RESET;
		end else begin
			if (wr_en_lp_lo) begin
				en_lp_q[LO_SOURCES-1:0] <= reg_wdata;
			end
			if (wr_en_lp_hi) begin
				en_lp_q[NUM_SOURCES-1:LO_SOURCES] <= reg_wdata[HI_SOURCES-1:0];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			en_hp_q <= EN_RESET;
		end else begin
			if (wr_en_hp_lo) begin
				en_hp_q[LO_SOURCES-1:0] <= reg_wdata;
			end
			if (wr_en_hp_hi) begin
				en_hp_q[NUM_SOURCES-1:LO_SOURCES] <= reg_wdata[HI_SOURCES-1:0];
			end
		end
	end

	// ========================================================================
	// Arbitration and dispatch
	logic [NUM_SOURCES-1:0]  flags_q;
	logic [NUM_SOURCES-1:0]  flags_d;
	logic [NUM_SOURCES-1:0]  clr_mask;
	logic                    found;
	logic [VEC_W-1:0]        winner;
	logic                    fire;
	logic [CNT_W-1:0]        cnt_q;

	prio_arbiter #(
		.N       (NUM_SOURCES)
	) u_arb (
		.pending (flags_q),
		.en_hp   (en_hp_q),
		.en_lp   (en_lp_q),
		.found   (found),
		.winner  (winner)
	);

	assign fire = found && (cnt_q == CNT_RESET);

	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			irq_req    <= 1'b0;
			irq_vector <= VEC_RESET;
		end else begin
			irq_req <= fire;
			if (fire) begin
				irq_vector <= winner;
			end
		end
	end

	// ========================================================================
	// Source flags
	always_comb begin
		clr_mask = '0;
		if (wr_flags_lo) begin
			clr_mask[LO_SOURCES-1:0] = reg_wdata;
		end
		if (wr_flags_hi) begin
			clr_mask[NUM_SOURCES-1:LO_SOURCES] = reg_wdata[HI_SOURCES-1:0];
		end
		flags_d = flags_q & ~clr_mask;
		if (fire) begin
			flags_d[winner] = 1'b0;
		end
		flags_d = flags_d | src_req;
	end

	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			flags_q <= FLAGS_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	// ========================================================================
	// Global gate counter
	logic [CNT_W:0]          cnt_sum;
	logic [CNT_W-1:0]        cnt_d;

	always_comb begin
		cnt_sum = {1'b0, cnt_q} + {3'h0, fire} + {3'h0, wr_dis};
		if (wr_ena && cnt_sum != 4'h0) begin
			cnt_sum = cnt_sum - 4'h1;
		end
		if (cnt_sum > {1'b0, CNT_MAX}) begin
			cnt_d = CNT_MAX;
		end else begin
			cnt_d = cnt_sum[CNT_W-1:0];
		end
		if (wr_cnt) begin
			cnt_d = reg_wdata[CNT_W-1:0];
		end
	end

	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cnt_q <= CNT_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// ========================================================================
	// Read data
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			if (reg_addr == ADDR_EN_LP_LO) begin
				reg_rdata <= en_lp_q[LO_SOURCES-1:0];
			end else if (reg_addr == ADDR_EN_LP_HI) begin
				reg_rdata <= {4'h0, en_lp_q[NUM_SOURCES-1:LO_SOURCES]};
			end else if (reg_addr == ADDR_EN_HP_LO) begin
				reg_rdata <= en_hp_q[LO_SOURCES-1:0];
			end else if (reg_addr == ADDR_EN_HP_HI) begin
				reg_rdata <= {4'h0, en_hp_q[NUM_SOURCES-1:LO_SOURCES]};
			end else if (reg_addr == ADDR_FLAGS_LO) begin
				reg_rdata <= flags_q[LO_SOURCES-1:0];
			end else if (reg_addr == ADDR_FLAGS_HI) begin
				reg_rdata <= {4'h0, flags_q[NUM_SOURCES-1:LO_SOURCES]};
			end else if (reg_addr == ADDR_VECTOR) begin
				reg_rdata <= {11'h000, irq_vector};
			end else if (reg_addr == ADDR_GATE_CNT) begin
				reg_rdata <= {13'h0000, cnt_q};
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end

	// ========================================================================
	// Checks
	logic [NUM_SOURCES-1:0]  pend_l3;
	logic [NUM_SOURCES-1:0]  pend_l2;
	logic [NUM_SOURCES-1:0]  pend_l1;
	logic [NUM_SOURCES-1:0]  pend_top;
	logic [NUM_SOURCES-1:0]  win_bit;

	assign pend_l3  = flags_q & en_hp_q & en_lp_q;
	assign pend_l2  = flags_q & en_hp_q & ~en_lp_q;
	assign pend_l1  = flags_q & ~en_hp_q & en_lp_q;
	assign pend_top = (pend_l3 != '0) ? pend_l3 : ((pend_l2 != '0) ? pend_l2 : pend_l1);
	assign win_bit  = NUM_SOURCES'(1) << winner;

	sequence s_dispatch;
		fire ##1 irq_req;
	endsequence

	chk_dispatch_pulse: assert property (@(posedge clock) disable iff (!rst_n_q)
		fire |-> ##1 irq_req ##0 (irq_vector == $past(winner)))
		else $error("Dispatch did not raise request with vector.");

	chk_gate_blocks: assert property (@(posedge clock) disable iff (!rst_n_q)
		(cnt_q != 3'h0) |-> !fire)
		else $error("Dispatch while gate counter nonzero.");

	chk_dispatch_incr: assert property (@(posedge clock) disable iff (!rst_n_q)
		(fire && !wr_dis && !wr_ena && !wr_cnt) |=> (cnt_q == 3'h1))
		else $error("Dispatch did not bump counter to one.");

	chk_double_incr: assert property (@(posedge clock) disable iff (!rst_n_q)
		(fire && wr_dis && !wr_ena && !wr_cnt) |=> (cnt_q == 3'h2))
		else $error("Dispatch with disable did not add two.");

	chk_disable_incr: assert property (@(posedge clock) disable iff (!rst_n_q)
		(wr_dis && !fire && !wr_ena && !wr_cnt && cnt_q < 3'h7) |=> (cnt_q == $past(cnt_q) + 3'h1))
		else $error("Disable write did not increment.");

	chk_enable_floor: assert property (@(posedge clock) disable iff (!rst_n_q)
		(wr_ena && !fire && !wr_dis && !wr_cnt) |=>
			(cnt_q == (($past(cnt_q) == 3'h0) ? 3'h0 : $past(cnt_q) - 3'h1)))
		else $error("Enable write decrement wrong.");

	chk_saturate: assert property (@(posedge clock) disable iff (!rst_n_q)
		(cnt_q == 3'h7 && !wr_ena && !wr_cnt) |=> (cnt_q == 3'h7))
		else $error("Gate counter wrapped.");

	chk_flag_set: assert property (@(posedge clock) disable iff (!rst_n_q)
		(src_req != '0) |=> ((flags_q & $past(src_req)) == $past(src_req)))
		else $error("Request did not set its flag.");

	chk_flag_clear: assert property (@(posedge clock) disable iff (!rst_n_q)
		(wr_flags_lo && !fire && src_req == '0) |=>
			(flags_q[15:0] == ($past(flags_q[15:0]) & ~$past(reg_wdata))))
		else $error("Flag write-one-clear wrong.");

	chk_masked_hold: assert property (@(posedge clock) disable iff (!rst_n_q)
		(flags_q[0] && !en_hp_q[0] && !en_lp_q[0] && !wr_flags_lo) |=> flags_q[0])
		else $error("Masked flag lost.");

	chk_seq_vector: assert property (@(posedge clock) disable iff (!rst_n_q)
		s_dispatch |=> (irq_vector == $past(irq_vector) || $past(fire)))
		else $error("Vector changed without dispatch.");

	sequence s_unblock;
		(wr_ena && !wr_dis && !wr_cnt && !fire && cnt_q == 3'h1) ##1 found;
	endsequence

	chk_resume_dispatch: assert property (@(posedge clock) disable iff (!rst_n_q)
		s_unblock |-> fire ##1 irq_req)
		else $error("Pending request not sent after release.");

	chk_fire_blocks: assert property (@(posedge clock) disable iff (!rst_n_q)
		(fire && !wr_ena && !wr_cnt) |=> !fire)
		else $error("Second dispatch without release.");

	chk_req_from_fire: assert property (@(posedge clock) disable iff (!rst_n_q)
		irq_req |-> $past(fire))
		else $error("Request without dispatch.");

	chk_req_gate_zero: assert property (@(posedge clock) disable iff (!rst_n_q)
		irq_req |-> ($past(cnt_q) == 3'h0))
		else $error("Request while gate counter nonzero.");

	chk_vector_stable: assert property (@(posedge clock) disable iff (!rst_n_q)
		!fire |=> $stable(irq_vector))
		else $error("Vector moved without dispatch.");

	chk_flag_autoclr: assert property (@(posedge clock) disable iff (!rst_n_q)
		(fire && (src_req & win_bit) == '0) |=> ((flags_q & $past(win_bit)) == '0))
		else $error("Dispatched flag not cleared.");

	chk_winner_valid: assert property (@(posedge clock) disable iff (!rst_n_q)
		found |-> (flags_q[winner] && (en_hp_q[winner] || en_lp_q[winner])))
		else $error("Winner not flagged and enabled.");

	chk_level_three: assert property (@(posedge clock) disable iff (!rst_n_q)
		(pend_l3 != '0) |-> (found && pend_l3[winner]))
		else $error("Level three not chosen first.");

	chk_level_two: assert property (@(posedge clock) disable iff (!rst_n_q)
		(pend_l3 == '0 && pend_l2 != '0) |-> (found && pend_l2[winner]))
		else $error("Level two not chosen next.");

	chk_level_one: assert property (@(posedge clock) disable iff (!rst_n_q)
		(pend_l3 == '0 && pend_l2 == '0 && pend_l1 != '0) |-> (found && pend_l1[winner]))
		else $error("Level one not chosen.");

	chk_masked_quiet: assert property (@(posedge clock) disable iff (!rst_n_q)
		((pend_l3 | pend_l2 | pend_l1) == '0) |-> !found)
		else $error("Masked source selected.");

	chk_tie_lowest: assert property (@(posedge clock) disable iff (!rst_n_q)
		found |-> ((pend_top & (win_bit - NUM_SOURCES'(1))) == '0))
		else $error("Equal level tie not lowest source.");

	chk_reset_clear: assert property (@(posedge clock)
		(!rst_n_q && !$past(rst_n_q)) |->
			(cnt_q == CNT_RESET && flags_q == FLAGS_RESET && !irq_req))
		else $error("State not cleared in reset.");

	chk_vector_read: assert property (@(posedge clock) disable iff (!rst_n_q)
		(reg_rd && reg_addr == ADDR_VECTOR) |=> (reg_rdata == {11'h000, $past(irq_vector)}))
		else $error("Vector read wrong.");

	chk_count_read: assert property (@(posedge clock) disable iff (!rst_n_q)
		(reg_rd && reg_addr == ADDR_GATE_CNT) |=> (reg_rdata == {13'h0000, $past(cnt_q)}))
		else $error("Counter read wrong.");

	chk_flag_read: assert property (@(posedge clock) disable iff (!rst_n_q)
		(reg_rd && reg_addr == ADDR_FLAGS_LO) |=> (reg_rdata == $past(flags_q[15:0])))
		else $error("Flag read wrong.");

	chk_read_no_side: assert property (@(posedge clock) disable iff (!rst_n_q)
		(reg_rd && !reg_wr && !fire && src_req == '0) |=> (flags_q == $past(flags_q)))
		else $error("Read changed flags.");

	chk_hi_unused: assert property (@(posedge clock) disable iff (!rst_n_q)
		(reg_rd && (reg_addr == ADDR_EN_LP_HI || reg_addr == ADDR_EN_HP_HI ||
			reg_addr == ADDR_FLAGS_HI)) |=> (reg_rdata[15:12] == 4'h0))
		else $error("Unused high bits read nonzero.");

	chk_clear_hi: assert property (@(posedge clock) disable iff (!rst_n_q)
		(wr_flags_hi && !fire && src_req == '0) |=>
			(flags_q[27:16] == ($past(flags_q[27:16]) & ~$past(reg_wdata[11:0]))))
		else $error("High flag write-one-clear wrong.");

	chk_enable_lo: assert property (@(posedge clock) disable iff (!rst_n_q)
		wr_en_lp_lo |=> (en_lp_q[15:0] == $past(reg_wdata)))
		else $error("Low enable write wrong.");

	chk_enable_hi: assert property (@(posedge clock) disable iff (!rst_n_q)
		wr_en_hp_hi |=> (en_hp_q[27:16] == $past(reg_wdata[11:0])))
		else $error("High enable write wrong.");

endmodule // prioritized_interrupt_controller

// >>> intc_pkg.sv
// Purpose: Constants and types for the prioritized interrupt controller.
// Assumes: 16-bit word-addressed register port, one clock, active-low reset.
// Notes:   Register offsets are word addresses as printed.
package intc_pkg;

	// ========================================================================
	// Register map
	localparam logic [15:0] ADDR_EN_LP_LO  = 16'hFC00;
	localparam logic [15:0] ADDR_EN_LP_HI  = 16'hFC01;
	localparam logic [15:0] ADDR_EN_HP_LO  = 16'hFC02;
	localparam logic [15:0] ADDR_EN_HP_HI  = 16'hFC03;
	localparam logic [15:0] ADDR_FLAGS_LO  = 16'hFC04;
	localparam logic [15:0] ADDR_FLAGS_HI  = 16'hFC05;
	localparam logic [15:0] ADDR_VECTOR    = 16'hFC06;
	localparam logic [15:0] ADDR_GATE_CNT  = 16'hFC07;
	localparam logic [15:0] ADDR_GLOB_DIS  = 16'hFC08;
	localparam logic [15:0] ADDR_GLOB_ENA  = 16'hFC09;

	// ========================================================================
	// Sizes and reset values
	localparam int          NUM_SOURCES    = 28;
	localparam int          LO_SOURCES     = 16;
	localparam int          HI_SOURCES     = 12;
	localparam int          VEC_W          = 5;
	localparam int          CNT_W          = 3;
	localparam logic [2:0]  CNT_MAX        = 3'h7;
	localparam logic [2:0]  CNT_RESET      = 3'h0;
	localparam logic [4:0]  VEC_RESET      = 5'h00;
	localparam logic [27:0] FLAGS_RESET    = 28'h0000000;
	localparam logic [27:0] EN_RESET       = 28'h0000000;

	typedef logic [1:0] prio_t;

endpackage

// >>> prio_arbiter.sv
// Purpose: Picks the highest-priority flagged source and its vector number.
// Assumes: Lower source number wins among equal levels.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module prio_arbiter
	import intc_pkg::*;
#(
	parameter int N = NUM_SOURCES
) (
	input  wire logic [N-1:0]     pending,
	input  wire logic [N-1:0]     en_hp,
	input  wire logic [N-1:0]     en_lp,
	output logic                  found,
	output logic [VEC_W-1:0]      winner
);

	// ========================================================================
	// Selection
	always_comb begin
		prio_t best;
		prio_t lvl;
		best   = 2'h0;
		lvl    = 2'h0;
		found  = 1'b0;
		winner = VEC_RESET;
		for (int i = 0; i < N; i++) begin
			lvl = {en_hp[i], en_lp[i]};
			if (pending[i] && lvl != 2'h0 && lvl > best) begin
				best   = lvl;
				found  = 1'b1;
				winner = VEC_W'(i);
			end
		end
	end

endmodule // prio_arbiter

// >>> core_model.sv
// Purpose: Core-side model that takes vectored interrupt requests.
// Assumes: irq_req is a one-cycle pulse on clock.
// Notes:   Counts requests and keeps the last vector taken.
`timescale 1ns/1ps
module core_model
	import intc_pkg::*;
(
	input  wire logic             clock,
	input  wire logic             irq_req,
	input  wire logic [VEC_W-1:0] irq_vector,
	output int                    taken,
	output logic      [VEC_W-1:0] vec_seen
);
	// ========================================================================
	// Acceptance
	int                    count_q = 0;

	assign taken = count_q;

	always @(negedge clock) begin
		if (irq_req === 1'b1) begin
			count_q  <= count_q + 1;
			vec_seen <= irq_vector;
		end
	end
endmodule // core_model

// >>> tb_prioritized_interrupt_controller.sv
// Purpose: Self-checking bench for the prioritized interrupt controller.
// Assumes: Register port and requests are driven on falling edges.
// Notes:   Handler ends are modelled by enable strobe writes.
`timescale 1ns/1ps
module tb_prioritized_interrupt_controller;
	import intc_pkg::*;
	typedef struct {logic [15:0] a, d, e;} row_t;
	logic                   clock, arst_n, reg_wr, reg_rd, irq_req;
	logic [NUM_SOURCES-1:0] src_req;
	logic [15:0]            reg_addr, reg_wdata, reg_rdata;
	logic [VEC_W-1:0]       irq_vector, vec_seen;
	int                     taken, miscompares, checks_done, i;
	logic [15:0]            exp_vec [3] = '{16'h0014, 16'h0009, 16'h0005};
	row_t                   rows [6] = '{'{16'hFC00, 16'hFFFF, 16'hFFFF},
		'{16'hFC01, 16'hFFFF, 16'h0FFF}, '{16'hFC02, 16'hA5A5, 16'hA5A5},
		'{16'hFC03, 16'hFFFF, 16'h0FFF}, '{16'hFC06, 16'h001F, 16'h0000},
		'{16'hFC0A, 16'h1234, 16'h0000}};

	prioritized_interrupt_controller i_prioritized_interrupt_controller (
		.clock(clock), .arst_n(arst_n), .src_req(src_req), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .irq_req(irq_req), .irq_vector(irq_vector));
	core_model i_core_model (.clock(clock), .irq_req(irq_req),
		.irq_vector(irq_vector), .taken(taken), .vec_seen(vec_seen));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ========================================================================
	// Tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		@(negedge clock);
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		@(negedge clock);
		chk(reg_rdata, exp);
	endtask
	task automatic do_reset;
		arst_n = 1'b0;
		repeat (2) @(negedge clock);
		arst_n = 1'b1;
		repeat (4) @(negedge clock);
	endtask
	task automatic complete_run;
		$display("Checks done %0d, miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wait_irq(input int n);
		int k;
		for (k = 0; k < 20 && taken < n; k++) @(negedge clock);
		if (taken < n) begin
			miscompares++;
			complete_run();
		end
	endtask

	// ========================================================================
	// Sequence
	initial begin
		{arst_n, reg_wr, reg_rd} = 3'h0;
		{src_req, reg_addr, reg_wdata} = '0;
		{miscompares, checks_done} = 0;
		do_reset();
		for (i = 0; i < 6; i++) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		do_reset();
		for (i = 0; i < 8; i++) rd(16'hFC00 + 16'(i), 16'h0000);
		src_req = 28'h80000FF;
		@(negedge clock);
		src_req = '0;
		rd(ADDR_FLAGS_LO, 16'h00FF);
		rd(ADDR_FLAGS_HI, 16'h0800);
		rd(ADDR_FLAGS_LO, 16'h00FF);
		wr(ADDR_FLAGS_LO, 16'hF00F);
		rd(ADDR_FLAGS_LO, 16'h00F0);
		chk(16'(taken), 16'h0000);
		wr(ADDR_FLAGS_LO, 16'hFFFF);
		wr(ADDR_FLAGS_HI, 16'hFFFF);
		wr(ADDR_GLOB_DIS, 16'h1234);
		wr(ADDR_EN_LP_LO, 16'h0020);
		wr(ADDR_EN_HP_LO, 16'h0200);
		wr(ADDR_EN_LP_HI, 16'h0010);
		wr(ADDR_EN_HP_HI, 16'h0010);
		src_req = 28'h0100220;
		@(negedge clock);
		src_req = '0;
		rd(ADDR_GATE_CNT, 16'h0001);
		chk(16'(taken), 16'h0000);
		for (i = 0; i < 3; i++) begin
			wr(ADDR_GLOB_ENA, 16'h0000);
			wait_irq(i + 1);
			chk(16'(vec_seen), exp_vec[i]);
			rd(ADDR_VECTOR, exp_vec[i]);
			rd(ADDR_GATE_CNT, 16'h0001);
		end
		rd(ADDR_FLAGS_LO, 16'h0000);
		rd(ADDR_FLAGS_HI, 16'h0000);
		wr(ADDR_GLOB_ENA, 16'h0000);
		wr(ADDR_GLOB_ENA, 16'hFFFF);
		rd(ADDR_GATE_CNT, 16'h0000);
		repeat (8) wr(ADDR_GLOB_DIS, 16'h0000);
		rd(ADDR_GATE_CNT, 16'h0007);
		repeat (7) wr(ADDR_GLOB_ENA, 16'h0001);
		wr(ADDR_EN_LP_LO, 16'h0008);
		src_req = 28'h0000008;
		@(negedge clock);
		src_req = '0;
		wr(ADDR_GLOB_DIS, 16'h0000);
		wait_irq(4);
		chk(16'(vec_seen), 16'h0003);
		rd(ADDR_GATE_CNT, 16'h0002);
		complete_run();
	end
endmodule // tb_prioritized_interrupt_controller
